// >>> dv/cimgr_bsp_model.sv
`timescale 1ns/10ps
module cimgr_bsp_model
   import cimgr_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire cimgr_bsp_out_type bo,
   input  wire logic              rx_go,
   output cimgr_bsp_in_type       bi
);
   logic [1:0] tick_ff;
   logic [2:0] rcnt_ff;
   // Idle bus stays recessive, so bus-free comes after eleven ticks
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bi      <= '0;
         tick_ff <= 2'h0;
         rcnt_ff <= 3'h0;
      end else begin
         tick_ff          <= tick_ff + 2'h1;
         bi.bit_tick      <= (tick_ff == 2'h0);
         bi.bit_recessive <= 1'b1;
         bi.tx_start      <= bo.tx_request && !bi.tx_active && !bi.tx_start;
         bi.tx_done_ok    <= bi.tx_active && bi.bit_tick && !bi.tx_done_ok;
         bi.tx_active     <= (bi.tx_active && !bi.tx_done_ok) || bi.tx_start;
         bi.rx_store_start <= rx_go;
         bi.rx_done       <= (rcnt_ff == 3'h1);
         rcnt_ff          <= rx_go ? 3'h4 : rcnt_ff - {2'h0, rcnt_ff != 3'h0};
      end
   end
endmodule // cimgr_bsp_model

// >>> dv/tb.sv
`timescale 1ns/10ps
module tb;
   import cimgr_pkg::*;
   logic              clk = 1'b0;
   logic              resetn = 1'b0;
   logic              ext_pin = 1'b0;
   logic [4:0]        cpu_addr = 5'h00;
   logic              cpu_wr = 1'b0;
   logic              cpu_rd = 1'b0;
   logic [7:0]        cpu_wdata = 8'h00;
   logic [7:0]        cpu_rdata;
   logic              cpu_irq;
   logic              rx_go = 1'b0;
   logic              dom0 = 1'b0;
   cimgr_bsp_in_type  bi;
   cimgr_bsp_out_type bo;
   int                errors = 0;
   int                num_checks = 0;
   int                cycles = 0;
   always #2.5 clk = ~clk;
   cimgr_top i_cimgr_top (.clk(clk), .resetn(resetn), .ext_reset_pin(ext_pin),
      .dom0_pin(dom0), .dom1_pin(1'b0), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
      .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
      .cpu_irq(cpu_irq), .bsp_in(bi), .bsp_out(bo));
   cimgr_bsp_model i_cimgr_bsp_model (.clk(clk), .resetn(resetn), .bo(bo),
      .rx_go(rx_go), .bi(bi));
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      cpu_addr = a;
      cpu_wdata = d;
      cpu_wr = 1'b1;
      @(posedge clk);
      #1;
      cpu_wr = 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] e, input string n);
      @(posedge clk);
      #1;
      cpu_addr = a;
      cpu_rd = 1'b1;
      @(posedge clk);
      #1;
      cpu_rd = 1'b0;
      check(n, cpu_rdata, e);
   endtask
   task automatic rx();
      @(posedge clk);
      #1 rx_go = 1'b1;
      @(posedge clk);
      #1 rx_go = 1'b0;
      repeat (8) @(posedge clk);
   endtask
   // Hang guard, the whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         errors++;
         conclude();
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      #1 resetn = 1'b1;
      rd(ADR_STAT, 8'h0C, "status");
      rd(ADR_CMD, 8'hCF, "command");
      wr(ADR_CFG_LO, 8'h5A);
      rd(ADR_CFG_LO, 8'h5A, "config");
      wr(ADR_CTRL, 8'h00);
      rd(ADR_CTRL, 8'h00, "control");
      rd(ADR_CFG_LO, 8'h00, "config locked");
      $display("test hold done");
      wr(ADR_CMD, 8'h01);
      check("request", {7'h00, bo.tx_request}, 8'h01);
      for (int i = 0; i < 50 && bi.tx_done_ok !== 1'b1; i++) @(posedge clk);
      repeat (3) @(posedge clk);
      rd(ADR_STAT, 8'h0C, "tx done");
      $display("test transmit done");
      repeat (3) rx();
      rd(ADR_STAT, 8'h0F, "overrun");
      wr(ADR_CMD, 8'h0C);
      rd(ADR_STAT, 8'h0D, "release");
      wr(ADR_CMD, 8'h04);
      rd(ADR_STAT, 8'h0C, "empty");
      $display("test receive done");
      wr(ADR_CTRL, 8'h02);
      rx();
      check("irq", {7'h00, cpu_irq}, 8'h01);
      rd(ADR_IRQ, 8'h01, "receive irq");
      rd(ADR_IRQ, 8'h00, "irq cleared");
      wr(ADR_CMD, 8'h30);
      rd(ADR_CMD, 8'hFF, "asleep");
      dom0 = 1'b1;
      repeat (4) @(posedge clk);
      #1 dom0 = 1'b0;
      rd(ADR_CMD, 8'hEF, "bus wake");
      rd(ADR_IRQ, 8'h10, "wake irq");
      wr(ADR_CMD, 8'h00);
      $display("test irq and wake done");
      @(posedge clk);
      #1 ext_pin = 1'b1;
      repeat (4) @(posedge clk);
      check("hold", {7'h00, bo.init_hold}, 8'h01);
      wr(ADR_CTRL, 8'h00);
      rd(ADR_CTRL, 8'h21, "pinned");
      rd(ADR_CMD, 8'hCF, "switches");
      ext_pin = 1'b0;
      $display("test pin reset done");
      conclude();
   end
endmodule // tb

// >>> verilog/cimgr_busfree_det.sv
`timescale 1ns/10ps
module cimgr_busfree_det #(
   parameter int unsigned BITS = cimgr_pkg::BUSFREE_BITS
) (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic restart,
   input  wire logic bit_tick,
   input  wire logic bit_recessive,
   output logic      busfree
);
   import cimgr_pkg::*;

   typedef struct packed {
      logic [7:0] run;
      logic       hit;
   } cimgr_bf_state_type;

   cimgr_bf_state_type bf_ff;
   cimgr_bf_state_type nxt_bf;

   initial begin
      if (BITS < 1 || BITS > 255) begin
         $error("cimgr_busfree_det: BITS out of range");
      end
   end

   always_comb begin
      nxt_bf     = bf_ff;
      nxt_bf.hit = 1'b0;
      if (restart) begin
         nxt_bf.run = 8'h00;
      end else if (bit_tick) begin
         if (!bit_recessive) begin
            nxt_bf.run = 8'h00;
         end else if (bf_ff.run == 8'(BITS - 1)) begin
            // Restart so each further run of idle bits counts again
            nxt_bf.run = 8'h00;
            nxt_bf.hit = 1'b1;
         end else begin
            nxt_bf.run = bf_ff.run + 8'h01;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bf_ff <= '{run: 8'h00, hit: 1'b0};
      end else begin
         bf_ff <= nxt_bf;
      end
   end

   assign busfree = bf_ff.hit;

endmodule // cimgr_busfree_det

// >>> verilog/cimgr_pkg.sv
package cimgr_pkg;

   // Control segment map, byte addresses of the CPU register port
   localparam logic [4:0] ADR_CTRL    = 5'h00;
   localparam logic [4:0] ADR_CMD     = 5'h01;
   localparam logic [4:0] ADR_STAT    = 5'h02;
   localparam logic [4:0] ADR_IRQ     = 5'h03;
   localparam logic [4:0] ADR_CFG_LO  = 5'h04;
   localparam logic [4:0] ADR_CFG_HI  = 5'h08;
   localparam logic [4:0] ADR_TXB_LO  = 5'h0A;
   localparam logic [4:0] ADR_TXB_HI  = 5'h13;

   // Control register fields
   localparam int unsigned CR_RR   = 0;
   localparam int unsigned CR_RIE  = 1;
   localparam int unsigned CR_OIE  = 4;
   localparam int unsigned CR_RA   = 5;
   localparam int unsigned CR_SYNC = 6;

   // Command register fields
   localparam int unsigned CMD_TR  = 0;
   localparam int unsigned CMD_AT  = 1;
   localparam int unsigned CMD_RRB = 2;
   localparam int unsigned CMD_COS = 3;
   localparam int unsigned CMD_SLP = 4;
   localparam int unsigned CMD_WSS = 5;
   localparam int unsigned CMD_SW1 = 6;
   localparam int unsigned CMD_SW0 = 7;
   localparam logic [3:0]  CMD_ACTION_READ = 4'hF;

   // Interrupt flag positions (low five bits of the interrupt register)
   localparam int unsigned IR_RI  = 0;
   localparam int unsigned IR_TI  = 1;
   localparam int unsigned IR_EI  = 2;
   localparam int unsigned IR_OI  = 3;
   localparam int unsigned IR_WUI = 4;

   // Counts
   localparam int unsigned BUSFREE_BITS       = 11;
   localparam logic [7:0]  BUSOFF_FREE_COUNT  = 8'h80;
   localparam logic [7:0]  RESET_FREE_COUNT   = 8'h01;
   localparam logic [7:0]  WARN_LIMIT_DEFAULT = 8'h60;
   localparam logic [1:0]  RX_STORES          = 2'h2;

   typedef enum logic [1:0] {ST_HOLD, ST_RECOVER, ST_ONLINE} cimgr_mode_type;

   typedef struct packed {
      logic       bit_tick;
      logic       bit_recessive;
      logic       tx_start;
      logic       tx_done_ok;
      logic       rx_store_start;
      logic       rx_done;
      logic       rx_own;
      logic       rx_active;
      logic       tx_active;
      logic       bus_off_evt;
      logic [7:0] tx_err_cnt;
      logic [7:0] rx_err_cnt;
      logic [3:0] tx_rd_idx;
   } cimgr_bsp_in_type;

   typedef struct packed {
      logic            init_hold;
      logic            tx_request;
      logic            rx_enable;
      logic            overrun_drop;
      logic            err_cnt_clear;
      logic [7:0]      tx_rd_data;
      logic            ref_active;
      logic            sync_both_edges;
      logic [4:0][7:0] cfg;
      logic            input0_switch_on;
      logic            input1_switch_on;
      logic            wake_sense_select;
      logic            sleeping;
   } cimgr_bsp_out_type;

   typedef struct packed {
      logic              ext_s1;
      logic              ext_s2;
      logic [1:0]        dom_s1;
      logic [1:0]        dom_s2;
      cimgr_mode_type    mode;
      logic              cause_busoff;
      logic [7:0]        free_cnt;
      logic              free_restart;
      logic [3:0]        ie;
      logic              sleep_request;
      logic              rx_block;
      logic              pending;
      logic              tx_buffer_released;
      logic              tx_complete_flag;
      logic              rs;
      logic              ts;
      logic              es;
      logic              bs;
      logic              dovr;
      logic              rx_buffer_full;
      logic [1:0]        rx_cnt;
      logic [4:0]        ir;
      logic [9:0][7:0]   txb;
      logic [7:0]        rdata;
      logic              irq;
      cimgr_bsp_out_type out;
   } cimgr_state_type;

   // After the global reset the block behaves as after an external reset
   localparam cimgr_bsp_out_type OUT_RESET = '{
      init_hold: 1'b1, tx_request: 1'b0, rx_enable: 1'b0, overrun_drop: 1'b0,
      err_cnt_clear: 1'b0, tx_rd_data: 8'h00, ref_active: 1'b1,
      sync_both_edges: 1'b0, cfg: 40'h00_0000_0000, input0_switch_on: 1'b1,
      input1_switch_on: 1'b1, wake_sense_select: 1'b0, sleeping: 1'b0};

   localparam cimgr_state_type STATE_RESET = '{
      ext_s1: 1'b0, ext_s2: 1'b0, dom_s1: 2'h0, dom_s2: 2'h0, mode: ST_HOLD,
      cause_busoff: 1'b0, free_cnt: 8'h00, free_restart: 1'b0, ie: 4'h0,
      sleep_request: 1'b0, rx_block: 1'b0, pending: 1'b0, tx_buffer_released: 1'b1, tx_complete_flag: 1'b1,
      rs: 1'b0, ts: 1'b0, es: 1'b0, bs: 1'b0, dovr: 1'b0, rx_buffer_full: 1'b0,
      rx_cnt: 2'h0, ir: 5'h00, txb: 80'h0, rdata: 8'h00, irq: 1'b0,
      out: OUT_RESET};

endpackage

// >>> verilog/cimgr_top.sv
`timescale 1ns/10ps
// Overview of operation
// - Reset pin or bus-off forces init hold
// - Clearing ignored during reset pin; software rechecks
// - Normal reset release waits one bus-free period
// - Bus-off release waits 128 periods, clears status
// - Config registers 4-8 only under init hold
// - Reference and resync writable only under hold
// - Entering hold clears sleep and request bits, switches on pin
// - Entering hold resets status (not bs, es) and RI/TI/OI flags
// - Command reads: low four bits read one
// - Transmit request starts; zero write cannot cancel
// - Abort cancels unstarted request, releases buffer
// - Buffer release clears full flag, may reset
// - Overrun clear command clears overrun flag
// - Sleep when idle, no interrupt; wake interrupts
// - Bus wake blocks reception until bus-free
// - Wake sense select: single-ended or differential
// - Input switch bits select receive sources
// - Both stores full: overrun, drop message
// - Own accepted message stored silently
// - Transmit buffer writes dropped while locked
// - Request clears complete; success sets it
// - Activity flags and error warning track state
// - Interrupt flags raise irq; read clears them
module cimgr_top #(
   parameter logic [7:0] WARN_LIMIT = cimgr_pkg::WARN_LIMIT_DEFAULT
) (
   input  wire logic                         clk,
   input  wire logic                         resetn,
   input  wire logic                         ext_reset_pin,
   input  wire logic                         dom0_pin,
   input  wire logic                         dom1_pin,
   input  wire logic [4:0]                   cpu_addr,
   input  wire logic                         cpu_wr,
   input  wire logic                         cpu_rd,
   input  wire logic [7:0]                   cpu_wdata,
   output logic [7:0]                        cpu_rdata,
   output logic                              cpu_irq,
   input  wire cimgr_pkg::cimgr_bsp_in_type  bsp_in,
   output cimgr_pkg::cimgr_bsp_out_type      bsp_out
);
   import cimgr_pkg::*;

   cimgr_state_type st_ff;
   cimgr_state_type nxt_st;
   logic            busfree;
   logic            ext;
   logic            wr_ctrl;
   logic            wr_cmd;
   logic            rd_irq;
   logic            enter_hold;
   logic            activity;
   logic            es_now;
   logic [7:0]      need;
   logic [4:0]      ir_set;

   initial begin
      if (WARN_LIMIT == 8'h00) begin
         $error("cimgr_top: WARN_LIMIT must be nonzero");
      end
   end

   cimgr_busfree_det #(
      .BITS          (BUSFREE_BITS)
   ) u_busfree (
      .clk           (clk),
      .resetn        (resetn),
      .restart       (st_ff.free_restart),
      .bit_tick      (bsp_in.bit_tick),
      .bit_recessive (bsp_in.bit_recessive),
      .busfree       (busfree)
   );

   always_comb begin
      nxt_st = st_ff;
      nxt_st.out.err_cnt_clear = 1'b0;
      nxt_st.free_restart      = 1'b0;
      ir_set = 5'h00;
      // Pin synchronisers; only the second stage is read below
      nxt_st.ext_s1 = ext_reset_pin;
      nxt_st.ext_s2 = st_ff.ext_s1;
      nxt_st.dom_s1 = {dom1_pin, dom0_pin};
      nxt_st.dom_s2 = st_ff.dom_s1;
      ext     = st_ff.ext_s2;
      wr_ctrl = cpu_wr && (cpu_addr == ADR_CTRL);
      wr_cmd  = cpu_wr && (cpu_addr == ADR_CMD);
      rd_irq  = cpu_rd && (cpu_addr == ADR_IRQ);
      es_now  = (bsp_in.tx_err_cnt >= WARN_LIMIT) || (bsp_in.rx_err_cnt >= WARN_LIMIT);
      need    = st_ff.cause_busoff ? BUSOFF_FREE_COUNT : RESET_FREE_COUNT;
      // Wake comparison follows the selected sense mode
      activity = st_ff.out.wake_sense_select ? (|st_ff.dom_s2) : (&st_ff.dom_s2);

      if (wr_ctrl) begin
         nxt_st.ie = cpu_wdata[CR_OIE:CR_RIE];
         if (st_ff.out.init_hold) begin
            // Still writable in the very write that drops the hold
            nxt_st.out.ref_active      = cpu_wdata[CR_RA];
            nxt_st.out.sync_both_edges = cpu_wdata[CR_SYNC];
         end
         nxt_st.out.init_hold = cpu_wdata[CR_RR] | ext;
      end

      if (wr_cmd) begin
         if (cpu_wdata[CMD_TR] && st_ff.tx_buffer_released && !st_ff.out.init_hold) begin
            nxt_st.pending = 1'b1;
            nxt_st.tx_buffer_released     = 1'b0;
            nxt_st.tx_complete_flag     = 1'b0;
         end
         if (cpu_wdata[CMD_AT] && st_ff.pending && !bsp_in.tx_start) begin
            nxt_st.pending = 1'b0;
            nxt_st.tx_buffer_released     = 1'b1;
            ir_set[IR_TI]  = st_ff.ie[IR_TI];
         end
         if (cpu_wdata[CMD_RRB] && st_ff.rx_cnt != 2'h0) begin
            nxt_st.rx_cnt = st_ff.rx_cnt - 2'h1;
            // A second held message is handed over at once
            nxt_st.rx_buffer_full    = (st_ff.rx_cnt == RX_STORES);
         end
         if (cpu_wdata[CMD_COS]) begin
            nxt_st.dovr = 1'b0;
         end
         nxt_st.sleep_request         = cpu_wdata[CMD_SLP];
         nxt_st.out.wake_sense_select = cpu_wdata[CMD_WSS];
         if (cpu_wdata[CMD_SW0] || cpu_wdata[CMD_SW1]) begin
            nxt_st.out.input0_switch_on = cpu_wdata[CMD_SW0];
            nxt_st.out.input1_switch_on = cpu_wdata[CMD_SW1];
         end
         if (!cpu_wdata[CMD_SLP] && st_ff.out.sleeping) begin
            nxt_st.out.sleeping = 1'b0;
            ir_set[IR_WUI]      = 1'b1;
         end
      end

      // Transmit path handshake with the bit-stream processor
      if (bsp_in.tx_start && st_ff.pending) begin
         nxt_st.pending = 1'b0;
      end
      if (bsp_in.tx_done_ok) begin
         nxt_st.tx_buffer_released    = 1'b1;
         nxt_st.tx_complete_flag    = 1'b1;
         ir_set[IR_TI] = st_ff.ie[IR_TI];
      end

      // Receive store allocation
      if (bsp_in.rx_store_start) begin
         if (nxt_st.rx_cnt == RX_STORES) begin
            nxt_st.dovr             = 1'b1;
            nxt_st.out.overrun_drop = 1'b1;
            ir_set[IR_OI]           = st_ff.ie[IR_OI];
         end else begin
            nxt_st.out.overrun_drop = 1'b0;
         end
      end
      if (bsp_in.rx_done && !st_ff.out.overrun_drop && nxt_st.rx_cnt != RX_STORES) begin
         nxt_st.rx_cnt = nxt_st.rx_cnt + 2'h1;
         if (!bsp_in.rx_own) begin
            nxt_st.rx_buffer_full    = 1'b1;
            ir_set[IR_RI] = st_ff.ie[IR_RI];
         end
      end

      // Status tracking
      nxt_st.rs = bsp_in.rx_active;
      nxt_st.ts = bsp_in.tx_active;
      if (st_ff.mode == ST_ONLINE) begin
         nxt_st.es = es_now;
      end
      if (bsp_in.bus_off_evt) begin
         nxt_st.bs = 1'b1;
         nxt_st.out.init_hold = 1'b1;
      end

      // Sleep entry and bus wake
      if (st_ff.sleep_request && !st_ff.out.sleeping && st_ff.mode == ST_ONLINE
          && !bsp_in.rx_active && !bsp_in.tx_active && !st_ff.irq) begin
         nxt_st.out.sleeping = 1'b1;
      end
      if (st_ff.out.sleeping && activity) begin
         nxt_st.out.sleeping = 1'b0;
         nxt_st.sleep_request = 1'b0;
         nxt_st.rx_block     = 1'b1;
         ir_set[IR_WUI]      = 1'b1;
      end
      if (busfree && !(st_ff.out.sleeping && activity)) begin
         nxt_st.rx_block = 1'b0;
      end

      // Interrupt register: read clears, a new event in that cycle survives
      if (rd_irq) begin
         nxt_st.ir = 5'h00;
      end
      if (nxt_st.es != st_ff.es || nxt_st.bs != st_ff.bs) begin
         ir_set[IR_EI] = st_ff.ie[IR_EI];
      end
      nxt_st.ir = nxt_st.ir | ir_set;

      // Entering hold, or holding the reset pin
      if (ext) begin
         nxt_st.out.init_hold = 1'b1;
      end
      enter_hold = nxt_st.out.init_hold && !st_ff.out.init_hold;
      if (enter_hold || ext) begin
         nxt_st.cause_busoff     = bsp_in.bus_off_evt && !ext;
         nxt_st.sleep_request    = 1'b0;
         nxt_st.out.sleeping     = 1'b0;
         nxt_st.pending          = 1'b0;
         nxt_st.rx_cnt           = 2'h0;
         nxt_st.out.overrun_drop = 1'b0;
         nxt_st.rs               = 1'b0;
         nxt_st.ts               = 1'b0;
         nxt_st.dovr             = 1'b0;
         nxt_st.rx_buffer_full              = 1'b0;
         nxt_st.tx_complete_flag              = 1'b1;
         nxt_st.tx_buffer_released              = 1'b1;
         nxt_st.ir[IR_OI]        = 1'b0;
         nxt_st.ir[IR_TI]        = 1'b0;
         nxt_st.ir[IR_RI]        = 1'b0;
      end
      if (ext) begin
         nxt_st.out.ref_active       = 1'b1;
         nxt_st.out.input0_switch_on = 1'b1;
         nxt_st.out.input1_switch_on = 1'b1;
         nxt_st.bs                   = 1'b0;
         nxt_st.es                   = 1'b0;
      end

      // Rejoin sequence after the hold is dropped
      case (st_ff.mode)
         ST_HOLD: begin
            if (!nxt_st.out.init_hold) begin
               nxt_st.mode         = ST_RECOVER;
               nxt_st.free_cnt     = 8'h00;
               nxt_st.free_restart = 1'b1;
            end
         end
         ST_RECOVER: begin
            if (busfree) begin
               if (st_ff.free_cnt + 8'h01 == need) begin
                  nxt_st.mode = ST_ONLINE;
                  if (st_ff.cause_busoff) begin
                     nxt_st.bs                = 1'b0;
                     nxt_st.es                = 1'b0;
                     nxt_st.out.err_cnt_clear = 1'b1;
                     nxt_st.cause_busoff      = 1'b0;
                  end
               end else begin
                  nxt_st.free_cnt = st_ff.free_cnt + 8'h01;
               end
            end
         end
         default: begin
         end
      endcase
      if (nxt_st.out.init_hold) begin
         nxt_st.mode = ST_HOLD;
      end

      // Register read port, data one cycle after the strobe
      if (cpu_rd) begin
         if (cpu_addr == ADR_CTRL) begin
            nxt_st.rdata = {1'b0, st_ff.out.sync_both_edges, st_ff.out.ref_active,
                            st_ff.ie, st_ff.out.init_hold};
         end else if (cpu_addr == ADR_CMD) begin
            nxt_st.rdata = {st_ff.out.input0_switch_on, st_ff.out.input1_switch_on,
                            st_ff.out.wake_sense_select, st_ff.out.sleeping,
                            CMD_ACTION_READ};
         end else if (cpu_addr == ADR_STAT) begin
            nxt_st.rdata = {st_ff.bs, st_ff.es, st_ff.ts, st_ff.rs,
                            st_ff.tx_complete_flag, st_ff.tx_buffer_released, st_ff.dovr, st_ff.rx_buffer_full};
         end else if (cpu_addr == ADR_IRQ) begin
            nxt_st.rdata = {3'h0, st_ff.ir};
         end else if (cpu_addr >= ADR_CFG_LO && cpu_addr <= ADR_CFG_HI) begin
            nxt_st.rdata = st_ff.out.init_hold ?
                           st_ff.out.cfg[3'(cpu_addr - ADR_CFG_LO)] : 8'h00;
         end else if (cpu_addr >= ADR_TXB_LO && cpu_addr <= ADR_TXB_HI) begin
            nxt_st.rdata = st_ff.txb[4'(cpu_addr - ADR_TXB_LO)];
         end else begin
            nxt_st.rdata = 8'h00;
         end
      end

      if (cpu_wr && cpu_addr >= ADR_CFG_LO && cpu_addr <= ADR_CFG_HI
          && st_ff.out.init_hold) begin
         nxt_st.out.cfg[3'(cpu_addr - ADR_CFG_LO)] = cpu_wdata;
      end
      // Locked buffer drops the byte with no error indication
      if (cpu_wr && cpu_addr >= ADR_TXB_LO && cpu_addr <= ADR_TXB_HI && st_ff.tx_buffer_released) begin
         nxt_st.txb[4'(cpu_addr - ADR_TXB_LO)] = cpu_wdata;
      end
      nxt_st.out.tx_rd_data = (bsp_in.tx_rd_idx <= 4'h9) ? st_ff.txb[bsp_in.tx_rd_idx] : 8'h00;

      nxt_st.out.tx_request = nxt_st.pending;
      nxt_st.out.rx_enable  = (nxt_st.mode == ST_ONLINE) && !nxt_st.rx_block
                              && !nxt_st.out.sleeping;
      nxt_st.irq            = |nxt_st.ir;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_ff <= STATE_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign cpu_rdata = st_ff.rdata;
   assign cpu_irq   = st_ff.irq;
   assign bsp_out   = st_ff.out;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   a_hold_on_pin: assert property (st_ff.ext_s2 |=> st_ff.out.init_hold)
      else $error("init hold not forced by reset pin");
   a_hold_busoff: assert property (bsp_in.bus_off_evt |=> st_ff.out.init_hold && st_ff.bs)
      else $error("bus-off did not force init hold");
   a_no_clr_pin: assert property (st_ff.ext_s2 && wr_ctrl && !cpu_wdata[CR_RR]
      |=> st_ff.out.init_hold) else $error("hold cleared under reset pin");
   a_rejoin_wait: assert property ($fell(st_ff.out.init_hold) |-> st_ff.mode == ST_RECOVER)
      else $error("rejoined without bus-free wait");
   a_cmd_read_one: assert property (cpu_rd && cpu_addr == ADR_CMD
      |=> cpu_rdata[3:0] == 4'hF) else $error("command low bits not one");
   a_tr_no_cancel: assert property (st_ff.pending && wr_cmd && !cpu_wdata[CMD_AT]
      && !bsp_in.tx_start && !enter_hold && !st_ff.ext_s2 |=> st_ff.pending)
      else $error("pending request lost");
   a_tr_clr_tcs: assert property (!st_ff.pending ##1 st_ff.pending |-> !st_ff.tx_complete_flag && !st_ff.tx_buffer_released)
      else $error("complete flag not cleared by request");
   a_overrun_set: assert property (bsp_in.rx_store_start && st_ff.rx_cnt == RX_STORES
      && !(wr_cmd && cpu_wdata[CMD_RRB]) && !enter_hold && !st_ff.ext_s2
      |=> st_ff.dovr && st_ff.out.overrun_drop) else $error("overrun not flagged");
   a_irq_follow: assert property (st_ff.irq == (st_ff.ir != 5'h00))
      else $error("irq out of step with flags");
   a_busoff_clear: assert property (st_ff.out.err_cnt_clear |-> !st_ff.bs && !st_ff.es
      && st_ff.mode == ST_ONLINE) else $error("bus-off recovery incomplete");

endmodule // cimgr_top
